// *** logic/segment_control_defines.svh ***
// Constants for the segment control map: register selects, field positions,
// legacy reset values and the implemented base width. Included by the decode and map RTL files.
`ifndef SEGMENT_CONTROL_DEFINES_SVH
`define SEGMENT_CONTROL_DEFINES_SVH

// ----------------------------------------------------------------------------
// Coprocessor-0 register numbers
// ----------------------------------------------------------------------------
`define SEG_CP0_REG_NUM        5'h05
`define SEG_CP0_SEL_REGIONS_0_1 3'h2
`define SEG_CP0_SEL_REGIONS_2_3 3'h3
`define SEG_CP0_SEL_REGIONS_4_5 3'h4
`define SEG_CP0_REG_CONFIG5    5'h10
`define SEG_CP0_SEL_CONFIG5    3'h5
`define SEG_CONFIG5_EXT_BIT    0

// ----------------------------------------------------------------------------
// Field positions inside one segment control word
// ----------------------------------------------------------------------------
`define SEG_EVEN_CACHE_LSB     0
`define SEG_EVEN_FLAG_BIT      3
`define SEG_EVEN_MODE_LSB      4
`define SEG_EVEN_BASE_LSB      9
`define SEG_ODD_CACHE_LSB      16
`define SEG_ODD_FLAG_BIT       19
`define SEG_ODD_MODE_LSB       20
`define SEG_ODD_BASE_LSB       25
`define SEG_BASE_IMPL_BITS     3

// ----------------------------------------------------------------------------
// Legacy reset values (undefined fields are taken as zero)
// ----------------------------------------------------------------------------
`define SEG_RST_REGIONS_0_1    32'h0020_0010
`define SEG_RST_REGIONS_2_3    32'h0003_0002
`define SEG_RST_REGIONS_4_5    32'h00B8_0438

`endif

// *** logic/segment_control_pkg.sv ***
// Types shared by the segment control map.
// Assumes it is compiled before any file that uses its types.
`default_nettype none

package segment_control_pkg;

	typedef enum logic [2:0] {
		MODE_KERNEL_UNMAPPED             = 3'h0,
		MODE_MAPPED_KERNEL               = 3'h1,
		MODE_MAPPED_KS                   = 3'h2,
		MODE_MAPPED_KSU                  = 3'h3,
		MODE_USER_MAPPED_KERNEL_UNMAPPED = 3'h4,
		MODE_OTHER5                      = 3'h5,
		MODE_OTHER6                      = 3'h6,
		MODE_OTHER7                      = 3'h7
	} access_mode_t;

	typedef struct packed {
		logic [6:0] physical_base;
		logic       error_level_flag;
		logic [2:0] access_mode;
		logic [2:0] cache_attribute;
	} region_cfg_t;

endpackage : segment_control_pkg

`default_nettype wire

// *** logic/segment_region_decode.sv ***
// Region lookup and unmapped address formation for one virtual address.
// Assumes the three segment words are stable for the cycle of the lookup.
`default_nettype none
`include "segment_control_defines.svh"

module segment_region_decode (
	input  wire logic [31:0] seg_word_0_1,     // Regions 0 and 1
	input  wire logic [31:0] seg_word_2_3,     // Regions 2 and 3
	input  wire logic [31:0] seg_word_4_5,     // Regions 4 and 5
	input  wire logic [31:0] virt_addr,        // Virtual address
	input  wire logic        kernel_mode,      // Access from kernel
	input  wire logic        error_level,      // Status error level set
	output logic      [2:0]  region_index,     // Selected region
	output segment_control_pkg::region_cfg_t region_cfg, // Its fields
	output logic             unmapped,         // Bypasses translation
	output logic      [31:0] phys_addr         // Unmapped physical address
);

	function automatic segment_control_pkg::region_cfg_t half_of(input logic [31:0] w, input logic odd);
		logic [15:0]                      h;
		segment_control_pkg::region_cfg_t c;
		h = odd ? w[31:16] : w[15:0]; // R5 R6
		c.cache_attribute  = h[2:0];
		c.error_level_flag = h[3];
		c.access_mode      = h[6:4];
		c.physical_base    = h[15:9];
		half_of = c;
	endfunction : half_of

	logic [31:0] off;

	always_comb begin
		// Fixed sizes: four half-gigabyte regions on top, two one-gigabyte below
		case (virt_addr[31:29]) // R7
			3'h7:    region_index = 3'd0;
			3'h6:    region_index = 3'd1;
			3'h5:    region_index = 3'd2;
			3'h4:    region_index = 3'd3;
			3'h3,
			3'h2:    region_index = 3'd4;
			default: region_index = 3'd5;
		endcase
		case (region_index)
			3'd0:    region_cfg = half_of(seg_word_0_1, 1'b0);
			3'd1:    region_cfg = half_of(seg_word_0_1, 1'b1);
			3'd2:    region_cfg = half_of(seg_word_2_3, 1'b0);
			3'd3:    region_cfg = half_of(seg_word_2_3, 1'b1);
			3'd4:    region_cfg = half_of(seg_word_4_5, 1'b0);
			default: region_cfg = half_of(seg_word_4_5, 1'b1);
		endcase
		case (segment_control_pkg::access_mode_t'(region_cfg.access_mode))
			segment_control_pkg::MODE_KERNEL_UNMAPPED: unmapped = 1'b1;
			segment_control_pkg::MODE_USER_MAPPED_KERNEL_UNMAPPED: unmapped = kernel_mode;
			default:                                   unmapped = 1'b0;
		endcase
		// Error-level flag lets the Status error level force an unmapped view for kernel-mode accesses only
		if (region_cfg.error_level_flag && error_level && kernel_mode) begin
			unmapped = 1'b1;
		end
		// One-gigabyte regions keep bit 29 from the address
		off = (region_index >= 3'd4) ? {2'b00, virt_addr[29:0]} : {3'b000, virt_addr[28:0]};
		phys_addr = {region_cfg.physical_base[2:0], 29'h0000_0000} | off; // R22
	end

endmodule : segment_region_decode

`default_nettype wire

// *** logic/segment_control_map.sv ***
// Segment control registers with legacy boot values, the extended-addressing
// enable and the per-access region lookup. Assumes a single-issue coprocessor-0
// move port and one fetch/data lookup port sampled per cycle.
//
// Functional notes
// [R1] Low boot select: extended enable clears to zero at boot.
// [R2] Low boot select: extended enable becomes software writable.
// [R3] Legacy boot loads all three segment words with legacy map values.
// [R4] Upper four physical base bits always read zero.
// [R5] Even region: cache 2:0, error flag 3, mode 6:4, base 15:9.
// [R6] Odd region: cache 18:16, error flag 19, mode 22:20, base 31:25.
// [R7] Regions 0-3 half gigabyte each from top; regions 4,5 one gigabyte.
// [R8] Legacy region 0: mapped kernel-only mode 001, error flag clear.
// [R9] Legacy region 1: kernel/supervisor mapped mode 010, error flag clear.
// [R10] Legacy region 2: kernel unmapped, uncached 2, flag and base zero.
// [R11] Legacy region 3: kernel unmapped, write-back 3, flag and base zero.
// [R12] Legacy regions 4,5: mode 011, flag set, bases 000001x and 000000x.
// [R13] Software first makes region 0 kernel unmapped uncached, base zero.
// [R14] Software copies boot code high, jumps there, initialises caches.
// [R15] Software sets region 1 mapped-kernel, regions 2-5 user-mapped kernel-unmapped.
// [R16] Software programs other regions before setting extended enable.
// [R17] Software moves kernel low, jumps, then finalises regions 0 and 1.
// [R18] Final regions 0,1: mapped-kernel mode, error flag clear.
// [R19] Final regions 2-5: write-back, flag set, user-mapped kernel-unmapped mode.
// [R20] Final bases of regions 2-5: 5, 4, 2, 0.
// [R21] First segment word is coprocessor-0 register 5 select 2.
// [R22] Unmapped access: physical base above bit 29 plus low address bits.
// [R23] Writes affect only accesses issued after the write completes.
`default_nettype none
`include "segment_control_defines.svh"

module segment_control_map (
	input  wire logic        sys_clk,          // Core clock
	input  wire logic        rst,              // Synchronous reset, high
	input  wire logic        extended_addressing_boot_select, // Boot strap
	input  wire logic        cp0_write,        // Move-to pulse
	input  wire logic        cp0_read,         // Move-from pulse
	input  wire logic  [4:0] cp0_reg,          // Register number
	input  wire logic  [2:0] cp0_sel,          // Select
	input  wire logic [31:0] cp0_wdata,        // Write data
	input  wire logic        lookup_valid,     // Access lookup request
	input  wire logic [31:0] lookup_vaddr,     // Virtual address
	input  wire logic        lookup_kernel,    // Kernel-mode access
	input  wire logic        lookup_error_level, // Status error level
	output logic      [31:0] cp0_rdata,        // Read data
	output logic             cp0_rvalid,       // Read data valid
	output logic             extended_addressing_enable_bit, // Scheme select
	output logic             lookup_done,      // Lookup answer valid
	output logic       [2:0] lookup_region,    // Selected region
	output logic             lookup_unmapped,  // Bypass translation
	output logic      [31:0] lookup_paddr,     // Physical address if unmapped
	output logic       [2:0] lookup_cache_attribute, // Region cache attribute
	output logic       [2:0] lookup_access_mode      // Region access mode
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef enum {
		BOOT_LOAD,
		RUN
	} phase_t;

	typedef struct packed {
		phase_t      phase;
		logic [31:0] segment_ctrl_regions_0_1;
		logic [31:0] segment_ctrl_regions_2_3;
		logic [31:0] segment_ctrl_regions_4_5;
		logic        ext_enable;
		logic        ext_writable;
		logic [31:0] rdata;
		logic        rvalid;
		logic        done;
		logic  [2:0] region;
		logic        unmapped;
		logic [31:0] paddr;
		logic  [2:0] cache_attr;
		logic  [2:0] mode;
	} state_t;

	state_t cur;
	state_t next_cur;

	// Unimplemented physical base bits forced low on every store
	function automatic logic [31:0] clean_word(input logic [31:0] w);
		clean_word = w;
		clean_word[`SEG_EVEN_BASE_LSB + 6 -: 4] = 4'h0; // R4
		clean_word[`SEG_ODD_BASE_LSB + 6 -: 4]  = 4'h0; // R4
	endfunction : clean_word

	function automatic logic hit(input logic [4:0] r, input logic [2:0] s, input logic [4:0] wr, input logic [2:0] ws);
		hit = (r == wr) && (s == ws);
	endfunction : hit

	// ------------------------------------------------------------------------
	// Region lookup on the registered words
	// ------------------------------------------------------------------------
	logic [2:0]                      dec_region;
	segment_control_pkg::region_cfg_t dec_cfg;
	logic                            dec_unmapped;
	logic [31:0]                     dec_paddr;

	// Registered words only: a write lands one cycle later, so a lookup
	// in the write cycle sees the old map and in-flight accesses are safe.
	segment_region_decode segment_region_decode_inst (
		.seg_word_0_1 (cur.segment_ctrl_regions_0_1), // R23
		.seg_word_2_3 (cur.segment_ctrl_regions_2_3),
		.seg_word_4_5 (cur.segment_ctrl_regions_4_5),
		.virt_addr    (lookup_vaddr),
		.kernel_mode  (lookup_kernel),
		.error_level  (lookup_error_level),
		.region_index (dec_region),
		.region_cfg   (dec_cfg),
		.unmapped     (dec_unmapped),
		.phys_addr    (dec_paddr)
	);

	// ------------------------------------------------------------------------
	// Register select decode
	// ------------------------------------------------------------------------
	logic sel_regions_0_1;
	logic sel_regions_2_3;
	logic sel_regions_4_5;
	logic sel_config5;

	// One decode shared by the move-to and move-from paths
	always_comb begin
		sel_regions_0_1 = hit(cp0_reg, cp0_sel, `SEG_CP0_REG_NUM, `SEG_CP0_SEL_REGIONS_0_1); // R21
		sel_regions_2_3 = hit(cp0_reg, cp0_sel, `SEG_CP0_REG_NUM, `SEG_CP0_SEL_REGIONS_2_3);
		sel_regions_4_5 = hit(cp0_reg, cp0_sel, `SEG_CP0_REG_NUM, `SEG_CP0_SEL_REGIONS_4_5);
		sel_config5     = hit(cp0_reg, cp0_sel, `SEG_CP0_REG_CONFIG5, `SEG_CP0_SEL_CONFIG5);
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		next_cur        = cur;
		next_cur.rvalid = 1'b0;
		next_cur.done   = 1'b0;
		case (cur.phase)
			BOOT_LOAD: begin
				// Strap sampled one edge after reset release
				next_cur.phase = RUN;
				if (!extended_addressing_boot_select) begin
					next_cur.segment_ctrl_regions_0_1 = `SEG_RST_REGIONS_0_1; // R3 R8 R9
					next_cur.segment_ctrl_regions_2_3 = `SEG_RST_REGIONS_2_3; // R3 R10 R11
					next_cur.segment_ctrl_regions_4_5 = `SEG_RST_REGIONS_4_5; // R3 R12
					next_cur.ext_enable               = 1'b0;                 // R1
					next_cur.ext_writable             = 1'b1;                 // R2
				end else begin
					// Extended boot: map values are the integrator's to load
					next_cur.ext_enable   = 1'b1;
					next_cur.ext_writable = 1'b0;
				end
			end
			RUN: begin
				if (cp0_write) begin
					if (sel_regions_0_1) begin
						next_cur.segment_ctrl_regions_0_1 = clean_word(cp0_wdata); // R21 R5 R6
					end
					if (sel_regions_2_3) begin
						next_cur.segment_ctrl_regions_2_3 = clean_word(cp0_wdata);
					end
					if (sel_regions_4_5) begin
						next_cur.segment_ctrl_regions_4_5 = clean_word(cp0_wdata);
					end
					// A high strap leaves the enable read-only
					if (sel_config5 && cur.ext_writable) begin
						next_cur.ext_enable = cp0_wdata[`SEG_CONFIG5_EXT_BIT]; // R2
					end
				end
				if (cp0_read) begin
					next_cur.rvalid = 1'b1;
					if (sel_regions_0_1) begin
						next_cur.rdata = cur.segment_ctrl_regions_0_1; // R21
					end else if (sel_regions_2_3) begin
						next_cur.rdata = cur.segment_ctrl_regions_2_3;
					end else if (sel_regions_4_5) begin
						next_cur.rdata = cur.segment_ctrl_regions_4_5;
					end else if (sel_config5) begin
						next_cur.rdata = {31'h0000_0000, cur.ext_enable};
					end else begin
						// Unknown selects read as zero
						next_cur.rdata = 32'h0000_0000;
					end
				end
				if (lookup_valid) begin
					next_cur.done       = 1'b1;
					next_cur.region     = dec_region;
					next_cur.unmapped   = dec_unmapped;
					next_cur.paddr      = dec_paddr; // R22
					next_cur.cache_attr = dec_cfg.cache_attribute;
					next_cur.mode       = dec_cfg.access_mode;
				end
			end
			default: begin
				next_cur.phase = BOOT_LOAD;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur <= '{phase: BOOT_LOAD, default: '0};
		end else begin
			cur <= next_cur;
		end
	end

	assign cp0_rdata                      = cur.rdata;
	assign cp0_rvalid                     = cur.rvalid;
	assign extended_addressing_enable_bit = cur.ext_enable;
	assign lookup_done                    = cur.done;
	assign lookup_region                  = cur.region;
	assign lookup_unmapped                = cur.unmapped;
	assign lookup_paddr                   = cur.paddr;
	assign lookup_cache_attribute         = cur.cache_attr;
	assign lookup_access_mode             = cur.mode;

endmodule : segment_control_map

`default_nettype wire

// *** tb/segment_control_map_checker.sv ***
// Concurrent checks on the ports of the segment control map.
// Assumes the boot strap is held steady while reset is low.
`default_nettype none

module segment_control_map_checker (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        extended_addressing_boot_select,
	input wire logic        cp0_write,
	input wire logic        cp0_read,
	input wire logic [4:0]  cp0_reg,
	input wire logic [2:0]  cp0_sel,
	input wire logic [31:0] cp0_wdata,
	input wire logic        lookup_valid,
	input wire logic [31:0] lookup_vaddr,
	input wire logic        lookup_kernel,
	input wire logic        lookup_error_level,
	input wire logic [31:0] cp0_rdata,
	input wire logic        cp0_rvalid,
	input wire logic        extended_addressing_enable_bit,
	input wire logic        lookup_done,
	input wire logic [2:0]  lookup_region,
	input wire logic        lookup_unmapped,
	input wire logic [31:0] lookup_paddr,
	input wire logic [2:0]  lookup_cache_attribute,
	input wire logic [2:0]  lookup_access_mode
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Top three address bits to region index
	function automatic logic [2:0] region_of(input logic [2:0] t);
		region_of = (t >= 3'h4) ? (3'h7 - t) : ((t >= 3'h2) ? 3'h4 : 3'h5);
	endfunction : region_of

	sequence s_rd_taken; cp0_read && !$past(rst); endsequence
	sequence s_lk_taken; lookup_valid && !$past(rst); endsequence
	property p_read_answer; s_rd_taken |=> cp0_rvalid; endproperty
	property p_base_zero; cp0_rvalid && $past(cp0_reg) == 5'h05 && $past(cp0_sel) inside {3'h2, 3'h3, 3'h4}
		|-> cp0_rdata[15:12] == 4'h0 && cp0_rdata[31:28] == 4'h0; endproperty
	property p_boot_legacy; $past(rst) && !extended_addressing_boot_select |=> !extended_addressing_enable_bit;
	endproperty
	property p_enable_write; cp0_write && cp0_reg == 5'h10 && cp0_sel == 3'h5 && !extended_addressing_boot_select
		&& !$past(rst) |=> extended_addressing_enable_bit == $past(cp0_wdata[0]); endproperty
	property p_enable_ro; extended_addressing_boot_select && !$past(rst) && !$past(rst, 2)
		|-> $stable(extended_addressing_enable_bit); endproperty
	property p_lookup_answer; s_lk_taken |=> lookup_done; endproperty
	property p_region; lookup_done |-> lookup_region == region_of($past(lookup_vaddr[31:29])); endproperty
	property p_paddr; lookup_done && lookup_unmapped && lookup_region < 3'h4
		|-> lookup_paddr[28:0] == $past(lookup_vaddr[28:0]); endproperty
	property p_mode_zero; lookup_done && lookup_access_mode == 3'h0 |-> lookup_unmapped; endproperty
	property p_mapped; lookup_done && lookup_access_mode inside {3'h1, 3'h2, 3'h3} && !$past(lookup_error_level)
		|-> !lookup_unmapped; endproperty

	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	a_base_zero: assert property (p_base_zero) else $error("upper base bits set");
	a_boot_legacy: assert property (p_boot_legacy) else $error("enable set on legacy boot");
	a_enable_write: assert property (p_enable_write) else $error("enable not written");
	a_enable_ro: assert property (p_enable_ro) else $error("enable changed after high strap");
	a_lookup_answer: assert property (p_lookup_answer) else $error("lookup not answered");
	a_region: assert property (p_region) else $error("wrong region");
	a_paddr: assert property (p_paddr) else $error("wrong low address bits");
	a_mode_zero: assert property (p_mode_zero) else $error("kernel unmapped region translated");
	a_mapped: assert property (p_mapped) else $error("mapped region bypassed");
endmodule : segment_control_map_checker

`default_nettype wire

// *** tb/test_segment_control_map.sv ***
// Self-checking bench for the segment control map.
// Drives every input at the falling edge; the checker is bound below.
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module test_segment_control_map;
	timeunit 1ns;
	timeprecision 100ps;
	logic        sys_clk = 1'b0, rst = 1'b1, strap = 1'b0, cp0_write = 1'b0, cp0_read = 1'b0;
	logic [4:0]  cp0_reg = 5'h00;
	logic [2:0]  cp0_sel = 3'h0;
	logic [31:0] cp0_wdata = 32'h0000_0000, lookup_vaddr = 32'h0000_0000, cp0_rdata, lookup_paddr;
	logic        lookup_valid = 1'b0, lookup_kernel = 1'b0, lookup_error_level = 1'b0;
	logic        cp0_rvalid, enable, lookup_done, lookup_unmapped;
	logic [2:0]  lookup_region, lookup_cache_attribute, lookup_access_mode;
	int          num_errors = 0, checks_done = 0;

	segment_control_map segment_control_map_inst (.sys_clk(sys_clk), .rst(rst),
		.extended_addressing_boot_select(strap), .cp0_write(cp0_write), .cp0_read(cp0_read), .cp0_reg(cp0_reg),
		.cp0_sel(cp0_sel), .cp0_wdata(cp0_wdata), .lookup_valid(lookup_valid), .lookup_vaddr(lookup_vaddr),
		.lookup_kernel(lookup_kernel), .lookup_error_level(lookup_error_level), .cp0_rdata(cp0_rdata),
		.cp0_rvalid(cp0_rvalid), .extended_addressing_enable_bit(enable), .lookup_done(lookup_done),
		.lookup_region(lookup_region), .lookup_unmapped(lookup_unmapped), .lookup_paddr(lookup_paddr),
		.lookup_cache_attribute(lookup_cache_attribute), .lookup_access_mode(lookup_access_mode));

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic boot(input logic s);
		@(negedge sys_clk);
		rst = 1'b1;
		strap = s;
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		// Let the boot load edge pass before any request
		@(negedge sys_clk);
	endtask : boot

	task automatic wr(input logic [4:0] r, input logic [2:0] s, input logic [31:0] d);
		@(negedge sys_clk);
		cp0_write = 1'b1;
		cp0_reg = r;
		cp0_sel = s;
		cp0_wdata = d;
		@(negedge sys_clk);
		cp0_write = 1'b0;
		cp0_wdata = ~d;
	endtask : wr

	task automatic rd(input logic [4:0] r, input logic [2:0] s, input logic [31:0] e);
		@(negedge sys_clk);
		cp0_read = 1'b1;
		cp0_reg = r;
		cp0_sel = s;
		@(negedge sys_clk);
		cp0_read = 1'b0;
		`CHK(cp0_rvalid, 1'b1)
		`CHK(cp0_rdata, e)
	endtask : rd

	// Paddr compared only where the region bypasses translation
	task automatic lk(input logic [31:0] va, input logic k, input logic el, input logic [2:0] rg,
		input logic um, input logic [31:0] pa, input logic [2:0] ca, input logic [2:0] md);
		@(negedge sys_clk);
		lookup_valid = 1'b1;
		lookup_vaddr = va;
		lookup_kernel = k;
		lookup_error_level = el;
		@(negedge sys_clk);
		lookup_valid = 1'b0;
		lookup_vaddr = ~va;
		`CHK(lookup_done, 1'b1)
		`CHK(lookup_region, rg)
		`CHK(lookup_unmapped, um)
		`CHK(lookup_cache_attribute, ca)
		`CHK(lookup_access_mode, md)
		if (um) `CHK(lookup_paddr, pa)
	endtask : lk

	task automatic t_legacy;
		`CHK(enable, 1'b0)
		rd(5'h05, 3'h2, 32'h0020_0010);
		rd(5'h05, 3'h3, 32'h0003_0002);
		rd(5'h05, 3'h4, 32'h00B8_0438);
		lk(32'hE000_0100, 1'b1, 1'b0, 3'h0, 1'b0, 32'h0, 3'h0, 3'h1);
		lk(32'hC000_0000, 1'b1, 1'b0, 3'h1, 1'b0, 32'h0, 3'h0, 3'h2);
		lk(32'hA000_1234, 1'b1, 1'b0, 3'h2, 1'b1, 32'h0000_1234, 3'h2, 3'h0);
		lk(32'h9FFF_FFFF, 1'b1, 1'b0, 3'h3, 1'b1, 32'h1FFF_FFFF, 3'h3, 3'h0);
		lk(32'h4000_0010, 1'b1, 1'b1, 3'h4, 1'b1, 32'h4000_0010, 3'h0, 3'h3);
		lk(32'h7FFF_FFF0, 1'b1, 1'b0, 3'h4, 1'b0, 32'h0, 3'h0, 3'h3);
		lk(32'h3FFF_FFFC, 1'b1, 1'b1, 3'h5, 1'b1, 32'h3FFF_FFFC, 3'h0, 3'h3);
		lk(32'h2000_0000, 1'b0, 1'b1, 3'h5, 1'b0, 32'h0, 3'h0, 3'h3);
	endtask : t_legacy

	task automatic t_fields;
		wr(5'h05, 3'h2, 32'hFFFF_FFFF);
		rd(5'h05, 3'h2, 32'h0FFF_0FFF);
		wr(5'h05, 3'h7, 32'hFFFF_FFFF);
		rd(5'h05, 3'h7, 32'h0000_0000);
		wr(5'h05, 3'h2, 32'h0020_0002);
		// Boot code now fetched from the top region through the temporary map
		lk(32'hE000_0100, 1'b1, 1'b0, 3'h0, 1'b1, 32'h0000_0100, 3'h2, 3'h0);
	endtask : t_fields

	// A write and a lookup taken at one edge: the lookup sees the old word
	task automatic t_switch;
		@(negedge sys_clk);
		cp0_write = 1'b1;
		cp0_reg = 5'h05;
		cp0_sel = 3'h3;
		cp0_wdata = 32'h084B_0A4B;
		lookup_valid = 1'b1;
		lookup_vaddr = 32'hA000_1234;
		lookup_kernel = 1'b1;
		lookup_error_level = 1'b0;
		@(negedge sys_clk);
		cp0_write = 1'b0;
		lookup_valid = 1'b0;
		`CHK(lookup_paddr, 32'h0000_1234)
		lk(32'hA000_1234, 1'b1, 1'b0, 3'h2, 1'b1, 32'hA000_1234, 3'h3, 3'h4);
		lk(32'h8000_0040, 1'b1, 1'b0, 3'h3, 1'b1, 32'h8000_0040, 3'h3, 3'h4);
		// Region 0 keeps the temporary map while the rest are reprogrammed
		wr(5'h05, 3'h2, 32'h0010_0002);
		wr(5'h05, 3'h4, 32'h004B_044B);
		rd(5'h05, 3'h4, 32'h004B_044B);
		lk(32'hC000_0000, 1'b1, 1'b0, 3'h1, 1'b0, 32'h0, 3'h0, 3'h1);
		lk(32'h4000_0010, 1'b1, 1'b0, 3'h4, 1'b1, 32'h4000_0010, 3'h3, 3'h4);
		lk(32'h0000_0100, 1'b1, 1'b0, 3'h5, 1'b1, 32'h0000_0100, 3'h3, 3'h4);
		lk(32'h0000_0100, 1'b0, 1'b0, 3'h5, 1'b0, 32'h0, 3'h3, 3'h4);
		wr(5'h10, 3'h5, 32'h0000_0001);
		`CHK(enable, 1'b1)
		rd(5'h10, 3'h5, 32'h0000_0001);
		// Kernel now runs low, so regions 0 and 1 take their final values
		wr(5'h05, 3'h2, 32'h0010_0010);
		rd(5'h05, 3'h2, 32'h0010_0010);
		lk(32'hE000_0100, 1'b1, 1'b0, 3'h0, 1'b0, 32'h0, 3'h0, 3'h1);
	endtask : t_switch

	task automatic t_strap_high;
		boot(1'b1);
		`CHK(enable, 1'b1)
		rd(5'h05, 3'h2, 32'h0000_0000);
		wr(5'h10, 3'h5, 32'h0000_0000);
		`CHK(enable, 1'b1)
	endtask : t_strap_high

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report

	initial begin
		#20000;
		num_errors++;
		final_report();
	end

	initial begin
		boot(1'b0);
		t_legacy();
		t_fields();
		t_switch();
		t_strap_high();
		final_report();
	end
endmodule : test_segment_control_map

bind segment_control_map segment_control_map_checker segment_control_map_checker_inst (.sys_clk(sys_clk),
	.rst(rst), .extended_addressing_boot_select(extended_addressing_boot_select), .cp0_write(cp0_write),
	.cp0_read(cp0_read), .cp0_reg(cp0_reg), .cp0_sel(cp0_sel), .cp0_wdata(cp0_wdata), .lookup_valid(lookup_valid),
	.lookup_vaddr(lookup_vaddr), .lookup_kernel(lookup_kernel), .lookup_error_level(lookup_error_level),
	.cp0_rdata(cp0_rdata), .cp0_rvalid(cp0_rvalid), .extended_addressing_enable_bit(extended_addressing_enable_bit),
	.lookup_done(lookup_done), .lookup_region(lookup_region), .lookup_unmapped(lookup_unmapped),
	.lookup_paddr(lookup_paddr), .lookup_cache_attribute(lookup_cache_attribute),
	.lookup_access_mode(lookup_access_mode));

`default_nettype wire
